// ---- src/lic_pkg.sv ----
// Constants and carrier types for the line interface control registers
package lic_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] ADDR_HOOK_RING   = 8'h05;   // Ring flags, monitor, hook
    localparam logic [7:0] ADDR_POWER       = 8'h06;   // Line and system power-down
    localparam logic [7:0] ADDR_RATE        = 8'h07;   // Sample rate select
    localparam logic [7:0] ADDR_RSVD_A      = 8'h08;   // Reserved, reads zero
    localparam logic [7:0] ADDR_RSVD_B      = 8'h09;   // Reserved, reads zero
    localparam logic [7:0] ADDR_LOOPBACK    = 8'h0A;   // Digital loopback

    // ========================================================================
    // Field positions
    localparam int BIT_RING_NEG     = 6;   // Negative ring flag
    localparam int BIT_RING_POS     = 5;   // Positive ring flag
    localparam int BIT_MONITOR      = 3;   // On-hook line monitor
    localparam int BIT_RING_IND     = 2;   // Ring indicator
    localparam int BIT_OFF_HOOK     = 0;   // Hook switch
    localparam int BIT_LINE_PD      = 4;   // Line-side power-down
    localparam int BIT_SYS_PD       = 3;   // System-side power-down
    localparam int BIT_DOUBLE_RATE  = 3;   // 16 kHz sampling select
    localparam int BIT_LOOPBACK     = 0;   // Receive-to-transmit loopback

    // ========================================================================
    // Reset values
    localparam logic [7:0] HOOK_RING_RESET = 8'h00;   // Hook register controls
    localparam logic [7:0] POWER_RESET     = 8'h10;   // Line side starts powered down
    localparam logic [7:0] RATE_RESET      = 8'h00;   // 8 kHz sampling
    localparam logic [7:0] LOOPBACK_RESET  = 8'h00;   // Loopback off

    // ========================================================================
    // Timing
    localparam longint CLK_HZ          = 200_000_000;  // Core clock rate
    localparam longint RING_HOLD_S     = 5;            // Ring indicator hold, seconds
    localparam int     RING_TIMER_W    = 30;           // Wide enough for the hold count
    localparam logic [RING_TIMER_W-1:0] RING_HOLD_COUNT =
        RING_TIMER_W'(RING_HOLD_S * CLK_HZ);           // Longest time, rounded down

    // ========================================================================
    // Serial control port framing: control byte, address byte, data byte
    localparam logic [4:0] SPI_ADDR_DONE  = 5'h10;     // Bits after address byte
    localparam logic [4:0] SPI_FRAME_DONE = 5'h18;     // Bits after data byte
    localparam int         SPI_READ_BIT   = 5;         // Read flag in control byte

    // ========================================================================
    // Register request from the serial port
    typedef struct packed
    {
        logic       valid;   // One-cycle write strobe
        logic [7:0] addr;    // Register address, held for reads
        logic [7:0] data;    // Write data
    } lic_req_t;

endpackage : lic_pkg

// ---- src/lic_spi_port.sv ----
// Serial control port slave that turns frames into register requests
`timescale 1ns/10ps

module lic_spi_port
(
    input  wire logic              clk,      // Core clock
    input  wire logic              rst,      // Asynchronous reset, active high
    input  wire logic              sclk,     // Serial clock pin
    input  wire logic              csN,      // Chip select pin, active low
    input  wire logic              sdi,      // Serial data in pin
    output logic                   sdoOut,   // Serial data out level
    output logic                   sdoOeN,   // Serial data out enable, active low
    output lic_pkg::lic_req_t      req,      // Request toward the register bank
    input  wire logic [7:0]        rdData    // Read data for req.addr
);
    import lic_pkg::*;

    // ========================================================================
    // State
    typedef struct packed
    {
        logic       sclkS1;    // Synchroniser stages
        logic       sclkS2;
        logic       sclkS3;    // Edge detect history
        logic       csS1;
        logic       csS2;
        logic       sdiS1;
        logic       sdiS2;
        logic [23:0] shift;    // Incoming frame
        logic [4:0] count;     // Bits taken this frame
        logic       isRead;    // Frame is a read
        logic       loadPend;  // Read data to be loaded
        logic [7:0] txShift;   // Outgoing read data
        logic       sdo;
        logic       oeN;
        lic_req_t   req;
    } lic_spi_state_t;

    lic_spi_state_t s_reg;   // Registered state
    lic_spi_state_t s_next;  // Next state

    // ========================================================================
    // Next state
    always_comb
    begin
        logic [23:0] newShift;
        logic [4:0]  newCount;
        logic        rise;
        logic        fall;
        newShift = {s_reg.shift[22:0], s_reg.sdiS2};
        newCount = s_reg.count + 5'h01;
        rise     = s_reg.sclkS2 & ~s_reg.sclkS3;
        fall     = ~s_reg.sclkS2 & s_reg.sclkS3;
        s_next   = s_reg;
        s_next.req.valid = 1'b0;
        // Pins pass two stages before use
        s_next.sclkS1 = sclk;
        s_next.sclkS2 = s_reg.sclkS1;
        s_next.sclkS3 = s_reg.sclkS2;
        s_next.csS1   = csN;
        s_next.csS2   = s_reg.csS1;
        s_next.sdiS1  = sdi;
        s_next.sdiS2  = s_reg.sdiS1;
        if (s_reg.csS2)
        begin
            // Deselected: frame aborts, output released
            s_next.count    = 5'h00;
            s_next.oeN      = 1'b1;
            s_next.loadPend = 1'b0;
            s_next.isRead   = 1'b0;
        end
        else
        begin
            // Data taken on rising serial clock
            if (rise && s_reg.count != SPI_FRAME_DONE)
            begin
                s_next.shift = newShift;
                s_next.count = newCount;
                if (newCount == SPI_ADDR_DONE)
                begin
                    s_next.req.addr = newShift[7:0];
                    s_next.isRead   = newShift[8 + SPI_READ_BIT];
                    s_next.loadPend = newShift[8 + SPI_READ_BIT];
                end
                if (newCount == SPI_FRAME_DONE && !s_reg.isRead)
                begin
                    s_next.req.valid = 1'b1;
                    s_next.req.data  = newShift[7:0];
                end
            end
            // Address is stable one cycle before read data is captured
            if (s_reg.loadPend)
            begin
                s_next.txShift  = rdData;
                s_next.loadPend = 1'b0;
            end
            // Read data changes on falling serial clock
            if (fall && s_reg.isRead && s_reg.count >= SPI_ADDR_DONE
                && s_reg.count < SPI_FRAME_DONE)
            begin
                s_next.sdo     = s_reg.txShift[7];
                s_next.txShift = {s_reg.txShift[6:0], 1'b0};
                s_next.oeN     = 1'b0;
            end
        end
    end

    // ========================================================================
    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg     <= '0;
            s_reg.csS1 <= 1'b1;
            s_reg.csS2 <= 1'b1;
            s_reg.oeN <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign sdoOut = s_reg.sdo;
    assign sdoOeN = s_reg.oeN;
    assign req    = s_reg.req;

endmodule : lic_spi_port

// ---- src/lic_line_interface_control.sv ----
// Hook, ring, power-down, sample rate and loopback control registers
`timescale 1ns/10ps

module lic_line_interface_control
#(
    parameter logic [lic_pkg::RING_TIMER_W-1:0] RING_HOLD_CYCLES = lic_pkg::RING_HOLD_COUNT
)
(
    input  wire logic   clk,                 // Core clock, 200 MHz
    input  wire logic   rst,                 // Asynchronous reset, active high
    input  wire logic   sclk,                // Serial control clock pin
    input  wire logic   csN,                 // Serial control select, active low
    input  wire logic   sdi,                 // Serial control data in
    output logic        sdoOut,              // Serial control data out
    output logic        sdoOeN,              // Data out enable, active low
    input  wire logic   ringPosPin,          // Positive ring present, from line side
    input  wire logic   ringNegPin,          // Negative ring present, from line side
    input  wire logic   fullWaveRingEnable,  // Full-wave ring select, same clock
    input  wire logic   serialReceivePin,    // Highway receive pin
    input  wire logic   codecTxData,         // Normal transmit data, same clock
    output logic        serialTransmitPin,   // Highway transmit pin
    output logic        offHook,             // Line side off-hook command
    output logic        onHookLineMonitor,   // Low-power on-hook monitoring
    output logic        lineSidePowerdown,   // Line side low-power mode
    output logic        systemSidePowerdown, // System side powered down
    output logic        doubleRateSampling,  // 16 kHz codec sampling
    output logic        ringIndicator        // Ring in progress
);
    import lic_pkg::*;

    // ========================================================================
    // State
    typedef struct packed
    {
        logic ringPosS1;        // Synchroniser stages
        logic ringPosS2;
        logic ringNegS1;
        logic ringNegS2;
        logic rxS1;
        logic rxS2;
        logic offHook;
        logic monitor;
        logic linePd;
        logic sysPd;
        logic doubleRate;
        logic loopback;
        logic ringInd;
        logic [RING_TIMER_W-1:0] ringTimer;  // Cycles left before indicator drops
        logic txPin;
    } lic_ctrl_state_t;

    lic_ctrl_state_t s_reg;   // Registered state
    lic_ctrl_state_t s_next;  // Next state
    lic_req_t        req;     // Request from the serial port
    logic [7:0]      rdData;  // Read data for req.addr

    // ========================================================================
    // Register readback; unmapped and reserved read zero
    function automatic logic [7:0] reg_read(input lic_ctrl_state_t st, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_HOOK_RING:
            begin
                v[BIT_RING_NEG] = st.ringNegS2;
                v[BIT_RING_POS] = st.ringPosS2;
                v[BIT_MONITOR]  = st.monitor;
                v[BIT_RING_IND] = st.ringInd;
                v[BIT_OFF_HOOK] = st.offHook;
            end
            ADDR_POWER:
            begin
                v[BIT_LINE_PD] = st.linePd;
                v[BIT_SYS_PD]  = st.sysPd;
            end
            ADDR_RATE:
            begin
                v[BIT_DOUBLE_RATE] = st.doubleRate;
            end
            ADDR_LOOPBACK:
            begin
                v[BIT_LOOPBACK] = st.loopback;
            end
            default:
            begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction : reg_read

    assign rdData = reg_read(s_reg, req.addr);

    // ========================================================================
    // Serial control port
    lic_spi_port u_port
    (
        .clk    (clk),
        .rst    (rst),
        .sclk   (sclk),
        .csN    (csN),
        .sdi    (sdi),
        .sdoOut (sdoOut),
        .sdoOeN (sdoOeN),
        .req    (req),
        .rdData (rdData)
    );

    // ========================================================================
    // Next state
    always_comb
    begin
        logic ringSet;
        logic hookRise;
        ringSet  = 1'b0;
        hookRise = 1'b0;
        s_next   = s_reg;
        // Line side and highway pins are asynchronous
        s_next.ringPosS1 = ringPosPin;
        s_next.ringPosS2 = s_reg.ringPosS1;
        s_next.ringNegS1 = ringNegPin;
        s_next.ringNegS2 = s_reg.ringNegS1;
        s_next.rxS1      = serialReceivePin;
        s_next.rxS2      = s_reg.rxS1;

        // Register writes; reserved bits and registers are dropped
        if (req.valid)
        begin
            unique case (req.addr)
                ADDR_HOOK_RING:
                begin
                    s_next.monitor = req.data[BIT_MONITOR];
                    s_next.offHook = req.data[BIT_OFF_HOOK];
                    hookRise       = req.data[BIT_OFF_HOOK] & ~s_reg.offHook;
                end
                ADDR_POWER:
                begin
                    s_next.linePd = req.data[BIT_LINE_PD];
                    // Sticky: a written zero does not wake the system side
                    if (req.data[BIT_SYS_PD])
                    begin
                        s_next.sysPd = 1'b1;
                    end
                end
                ADDR_RATE:
                begin
                    s_next.doubleRate = req.data[BIT_DOUBLE_RATE];
                end
                ADDR_LOOPBACK:
                begin
                    s_next.loopback = req.data[BIT_LOOPBACK];
                end
                default:
                begin
                    s_next.loopback = s_reg.loopback;
                end
            endcase
        end

        // Ring indicator: polarity qualified by full-wave select
        ringSet = s_reg.ringPosS2 | (fullWaveRingEnable & s_reg.ringNegS2);
        if (hookRise)
        begin
            // Going off-hook drops the indicator at once
            s_next.ringInd   = 1'b0;
            s_next.ringTimer = '0;
        end
        else if (ringSet)
        begin
            // Every ring restarts the hold window
            s_next.ringInd   = 1'b1;
            s_next.ringTimer = RING_HOLD_CYCLES;
        end
        else if (s_reg.ringInd)
        begin
            if (s_reg.ringTimer <= RING_TIMER_W'(1))
            begin
                s_next.ringInd   = 1'b0;
                s_next.ringTimer = '0;
            end
            else
            begin
                s_next.ringTimer = s_reg.ringTimer - RING_TIMER_W'(1);
            end
        end

        // Loopback bypasses the filters; the frame slotting stays with the
        // highway logic, which keeps 8 kHz frames in double-rate mode
        s_next.txPin = s_reg.loopback ? s_reg.rxS2 : codecTxData;
    end

    // ========================================================================
    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg            <= '0;
            s_reg.offHook    <= HOOK_RING_RESET[BIT_OFF_HOOK];
            s_reg.monitor    <= HOOK_RING_RESET[BIT_MONITOR];
            s_reg.linePd     <= POWER_RESET[BIT_LINE_PD];
            s_reg.sysPd      <= POWER_RESET[BIT_SYS_PD];
            s_reg.doubleRate <= RATE_RESET[BIT_DOUBLE_RATE];
            s_reg.loopback   <= LOOPBACK_RESET[BIT_LOOPBACK];
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ========================================================================
    // Outputs, all from flip-flops
    assign serialTransmitPin   = s_reg.txPin;
    assign offHook             = s_reg.offHook;
    assign onHookLineMonitor   = s_reg.monitor;
    assign lineSidePowerdown   = s_reg.linePd;
    assign systemSidePowerdown = s_reg.sysPd;
    assign doubleRateSampling  = s_reg.doubleRate;
    assign ringIndicator       = s_reg.ringInd;

endmodule : lic_line_interface_control

// ---- sim/lic_line_interface_control_checker.sv ----
// Port-level assertions for the line interface control block
`timescale 1ns/10ps
module lic_line_interface_control_checker
#(
    parameter logic [29:0] RING_HOLD_CYCLES = 30'd20
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sdoOeN,
    input wire logic ringPosPin,
    input wire logic ringNegPin,
    input wire logic fullWaveRingEnable,
    input wire logic serialReceivePin,
    input wire logic codecTxData,
    input wire logic serialTransmitPin,
    input wire logic offHook,
    input wire logic lineSidePowerdown,
    input wire logic systemSidePowerdown,
    input wire logic ringIndicator
);
    // ========================================================================
    // Helper logic
    localparam int HOLD = int'(RING_HOLD_CYCLES);  // Indicator hold, cycles
    logic        ringAct;   // A ring that may set the indicator
    logic [31:0] quietCnt;  // Cycles since such a ring
    logic [3:0]  actHist;   // Recent ring activity
    logic [2:0]  sinceRst;  // Saturating, hides sync fill after reset
    assign ringAct = ringPosPin || (ringNegPin && fullWaveRingEnable);
    // Margins of a few cycles absorb the pin synchroniser
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            quietCnt <= '0;
            actHist  <= '0;
            sinceRst <= '0;
        end
        else
        begin
            quietCnt <= ringAct ? 32'h0 : quietCnt + {31'h0, ~quietCnt[31]};
            actHist  <= {actHist[2:0], ringAct};
            sinceRst <= sinceRst + {2'b00, ~&sinceRst};
        end
    end
    // ========================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RING_POS_SET: assert property (ringPosPin[*4] ##0 (sinceRst == 3'd7 && !$rose(offHook))
        |-> ringIndicator) else $error("Indicator low under steady positive ring");
    AST_RING_CAUSE: assert property ($rose(ringIndicator) |-> actHist != 4'h0)
        else $error("Indicator set without a qualifying ring");
    AST_RING_NEG_FULL: assert property ((ringNegPin && fullWaveRingEnable)[*4]
        ##0 (sinceRst == 3'd7 && !$rose(offHook)) |-> ringIndicator) else $error("Full-wave miss");
    AST_RING_HOLD: assert property ($fell(ringIndicator)
        |-> $rose(offHook) || quietCnt >= 32'(HOLD - 2)) else $error("Indicator dropped early");
    AST_RING_EXPIRE: assert property (quietCnt == 32'(HOLD + 8) |-> !ringIndicator)
        else $error("Indicator outlived its hold");
    AST_OFFHOOK_CLEARS: assert property ($rose(offHook) |-> !ringIndicator)
        else $error("Indicator survived off-hook");
    AST_RESET_VALUES: assert property (disable iff (1'b0) rst
        |-> lineSidePowerdown && !systemSidePowerdown && !offHook && !ringIndicator && sdoOeN)
        else $error("Wrong output level in reset");
    AST_SYS_PD_RESET_ONLY: assert property (disable iff (1'b0) $fell(systemSidePowerdown)
        |-> rst) else $error("System power-down left without reset");
    AST_TX_PATH: assert property (sinceRst == 3'd7 |-> serialTransmitPin ==
        $past(serialReceivePin, 3) || serialTransmitPin == $past(codecTxData))
        else $error("Transmit pin from neither source");
    COV_OFFHOOK: cover property ($rose(offHook));
    COV_RING_EXPIRE: cover property ($fell(ringIndicator) && !$rose(offHook));
    COV_SYS_PD: cover property ($rose(systemSidePowerdown));
endmodule : lic_line_interface_control_checker

bind lic_line_interface_control lic_line_interface_control_checker
    #(.RING_HOLD_CYCLES(RING_HOLD_CYCLES)) chk_u
    (.clk(clk), .rst(rst), .sdoOeN(sdoOeN), .ringPosPin(ringPosPin), .ringNegPin(ringNegPin),
     .fullWaveRingEnable(fullWaveRingEnable), .serialReceivePin(serialReceivePin),
     .codecTxData(codecTxData), .serialTransmitPin(serialTransmitPin), .offHook(offHook),
     .lineSidePowerdown(lineSidePowerdown), .systemSidePowerdown(systemSidePowerdown),
     .ringIndicator(ringIndicator));

// ---- sim/lic_host_model.sv ----
// Host processor model driving the serial control port
`timescale 1ns/10ps
module lic_host_model
(
    input  wire logic clk,     // Paces the serial phases
    output logic      sclk,    // Stands low outside frames
    output logic      csN,     // Select, active low
    output logic      sdi,     // Data toward the block
    input  wire logic sdoOut,  // Read data level
    input  wire logic sdoOeN   // Read data enable, active low
);
    // ========================================================================
    // Frame engine
    localparam int PHASE = 6;  // Clocks per phase, sync needs three
    initial
    begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end
    // Control, address, data, MSB first; read bits sampled before each rise
    task automatic xfer(input logic [7:0] ctl, input logic [7:0] addr,
                        input logic [7:0] wdat, output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {ctl, addr, wdat};
        rdat  = 8'h00;
        @(posedge clk) csN <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sclk <= 1'b0;
            sdi  <= frame[i];
            repeat (PHASE) @(posedge clk);
            if (i < 8)
                rdat[i] = (sdoOeN === 1'b0) ? sdoOut : 1'bx;  // Undriven line is no data
            sclk <= 1'b1;
            repeat (PHASE) @(posedge clk);
        end
        sclk <= 1'b0;
        repeat (PHASE) @(posedge clk);
        csN <= 1'b1;
        sdi <= ~sdi;  // Released line shows no stale level
        repeat (PHASE) @(posedge clk);
    endtask : xfer
endmodule : lic_host_model

// ---- sim/tb_lic_line_interface_control.sv ----
// Self-checking bench for the line interface control registers
`timescale 1ns/10ps
module tb_lic_line_interface_control;
    import lic_pkg::*;
    // ========================================================================
    // Signals
    localparam logic [29:0] HOLD = 30'd2000;  // Shortened ring hold
    logic clk = 1'b0, rst = 1'b0, sclk, csN, sdi, sdoOut, sdoOeN;
    logic ringPosPin = 1'b0, ringNegPin = 1'b0, fullWaveRingEnable = 1'b0;
    logic serialReceivePin = 1'b0, codecTxData = 1'b0, serialTransmitPin;
    logic offHook, onHookLineMonitor, lineSidePowerdown, systemSidePowerdown;
    logic doubleRateSampling, ringIndicator;
    int   nMismatch = 0;
    int   checksDone = 0;
    always #2.5 clk = ~clk;
    lic_line_interface_control #(.RING_HOLD_CYCLES(HOLD)) dut_u
    (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut),
     .sdoOeN(sdoOeN), .ringPosPin(ringPosPin), .ringNegPin(ringNegPin),
     .fullWaveRingEnable(fullWaveRingEnable), .serialReceivePin(serialReceivePin),
     .codecTxData(codecTxData), .serialTransmitPin(serialTransmitPin), .offHook(offHook),
     .onHookLineMonitor(onHookLineMonitor), .lineSidePowerdown(lineSidePowerdown),
     .systemSidePowerdown(systemSidePowerdown), .doubleRateSampling(doubleRateSampling),
     .ringIndicator(ringIndicator));
    lic_host_model host_u
    (.clk(clk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdoOut(sdoOut), .sdoOeN(sdoOeN));
    // ========================================================================
    // Tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : chk
    task automatic pin(input logic seen, input logic exp);
        chk({7'h00, seen}, {7'h00, exp});
    endtask : pin
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] q;
        host_u.xfer(8'h00, addr, data, q);
    endtask : wr
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] q;
        host_u.xfer(8'h20, addr, 8'h00, q);
        chk(q, exp);
    endtask : rd
    // Transmit pin against receive (lb) or normal data, d cycles late
    task automatic lbrun(input logic lb, input int d);
        logic [15:0] pat;
        pat = 16'hB4C3;
        for (int j = 0; j < 16; j++)
        begin
            @(posedge clk);
            serialReceivePin <= pat[j];
            codecTxData      <= ~pat[j];
            @(negedge clk);
            if (j >= d)
                pin(serialTransmitPin, lb ? pat[j-d] : ~pat[j-d]);
        end
    endtask : lbrun
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // ========================================================================
    // Sequence
    initial
    begin
        // Edge on reset at time zero so outputs settle before the first clock
        rst <= 1'b1;
        waitc(5);
        rst <= 1'b0;
        waitc(3);
        rd(ADDR_HOOK_RING, 8'h00);
        rd(ADDR_POWER, 8'h10);
        rd(ADDR_LOOPBACK, 8'h00);
        pin(lineSidePowerdown, 1'b1);
        wr(ADDR_HOOK_RING, 8'hFF);
        rd(ADDR_HOOK_RING, 8'h09);
        pin(offHook, 1'b1);
        pin(onHookLineMonitor, 1'b1);
        wr(ADDR_HOOK_RING, 8'h00);
        pin(offHook, 1'b0);
        pin(onHookLineMonitor, 1'b0);
        for (int r = 8; r <= 9; r++)
        begin
            wr(8'(r), 8'hFF);
            rd(8'(r), 8'h00);
        end
        // Clocking set up before line power-up; flags to clear live elsewhere
        wr(ADDR_RATE, 8'hFF);
        rd(ADDR_RATE, 8'h08);
        pin(doubleRateSampling, 1'b1);
        wr(ADDR_POWER, 8'hE7);
        rd(ADDR_POWER, 8'h00);
        pin(lineSidePowerdown, 1'b0);
        wr(ADDR_POWER, 8'h08);
        wr(ADDR_POWER, 8'h00);
        rd(ADDR_POWER, 8'h08);
        pin(systemSidePowerdown, 1'b1);
        rst <= 1'b1;
        waitc(5);
        rst <= 1'b0;
        waitc(3);
        pin(systemSidePowerdown, 1'b0);
        rd(ADDR_POWER, 8'h10);
        rd(ADDR_RATE, 8'h00);
        ringPosPin <= 1'b1;
        rd(ADDR_HOOK_RING, 8'h24);
        pin(ringIndicator, 1'b1);
        ringPosPin <= 1'b0;
        waitc(int'(HOLD) - 20);
        pin(ringIndicator, 1'b1);
        waitc(40);
        pin(ringIndicator, 1'b0);
        ringNegPin <= 1'b1;
        rd(ADDR_HOOK_RING, 8'h40);
        pin(ringIndicator, 1'b0);
        fullWaveRingEnable <= 1'b1;
        waitc(6);
        pin(ringIndicator, 1'b1);
        ringNegPin <= 1'b0;
        wr(ADDR_HOOK_RING, 8'h01);
        pin(ringIndicator, 1'b0);
        wr(ADDR_HOOK_RING, 8'h00);
        lbrun(1'b0, 1);
        wr(ADDR_LOOPBACK, 8'hFF);
        rd(ADDR_LOOPBACK, 8'h01);
        lbrun(1'b1, 3);
        finish_test();
    end
    // Watchdog against a hung sequence
    initial
    begin
        waitc(100000);
        nMismatch++;
        finish_test();
    end
endmodule : tb_lic_line_interface_control
